// [mbdio_bridge.sv]
module mbdio_bridge
    import mbdio_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // backplane bus
    input wire mbdio_bus_ctl_t bus_ctl_in,
    input wire logic [DATA_W-1:0] bus_data_n_in,
    output logic [DATA_W-1:0] bus_data_n_out,
    output logic bus_data_oe_out,
    output logic bus_irq_n_out,
    output logic module_active_n_out,
    // board switches and straps
    input wire mbdio_cfg_t cfg_in,
    // adapter side
    output mbdio_adp_ctl_t adp_ctl_out,
    input wire logic [DATA_W-1:0] adp_data_in [NUM_ADAPTERS],
    output logic [DATA_W-1:0] adp_data_out,
    input wire logic [NUM_ADAPTERS-1:0] adp_irq_n_in,
    // adapter port data, index 2*adapter + (0 = A, 1 = B)
    input wire logic [DATA_W-1:0] adp_port_in [NUM_PORTS],
    output logic [DATA_W-1:0] adp_port_out [NUM_PORTS],
    input wire logic [DATA_W-1:0] ext_port_in [NUM_PORTS],
    output logic [DATA_W-1:0] ext_port_out [NUM_PORTS],
    output logic [NUM_PORTS-1:0] ext_port_oe_out,
    // control lines: first/second per port; adapter oe high = adapter drives
    input wire logic [NUM_PORTS-1:0] adp_ctrl_first_in,
    input wire logic [NUM_PORTS-1:0] adp_ctrl_second_in,
    input wire logic [NUM_PORTS-1:0] adp_ctrl_second_oe_in,
    output logic [NUM_PORTS-1:0] adp_ctrl_first_out,
    output logic [NUM_PORTS-1:0] adp_ctrl_second_out,
    input wire logic [NUM_PORTS-1:0] ext_ctrl_first_in,
    input wire logic [NUM_PORTS-1:0] ext_ctrl_second_in,
    output logic [NUM_PORTS-1:0] ext_ctrl_first_out,
    output logic [NUM_PORTS-1:0] ext_ctrl_second_out,
    output logic [NUM_PORTS-1:0] ext_ctrl_first_oe_out,
    output logic [NUM_PORTS-1:0] ext_ctrl_second_oe_out
);

    // every input pin except rst_n_in passes two flops; decode then adds one register stage
    mbdio_bus_ctl_t bus_s1_r, bus_s2_r;
    mbdio_cfg_t cfg_s1_r, cfg_s2_r;
    logic [DATA_W-1:0] bdat_s1_r, bdat_s2_r;
    logic [NUM_ADAPTERS-1:0] irq_s1_r, irq_s2_r;
    logic [DATA_W-1:0] adat_s1_r [NUM_ADAPTERS];
    logic [DATA_W-1:0] adat_s2_r [NUM_ADAPTERS];
    logic [DATA_W-1:0] aport_s1_r [NUM_PORTS];
    logic [DATA_W-1:0] aport_s2_r [NUM_PORTS];
    logic [DATA_W-1:0] eport_s1_r [NUM_PORTS];
    logic [DATA_W-1:0] eport_s2_r [NUM_PORTS];
    logic [NUM_PORTS-1:0] a1_s1_r, a1_s2_r, a2_s1_r, a2_s2_r, a2oe_s1_r, a2oe_s2_r;
    logic [NUM_PORTS-1:0] e1_s1_r, e1_s2_r, e2_s1_r, e2_s2_r;

    always_ff @(posedge sys_clk_in)
    begin
        bus_s1_r <= bus_ctl_in;
        bus_s2_r <= bus_s1_r;
        cfg_s1_r <= cfg_in;
        cfg_s2_r <= cfg_s1_r;
        bdat_s1_r <= bus_data_n_in;
        bdat_s2_r <= bdat_s1_r;
        irq_s1_r <= adp_irq_n_in;
        irq_s2_r <= irq_s1_r;
        adat_s1_r <= adp_data_in;
        adat_s2_r <= adat_s1_r;
        aport_s1_r <= adp_port_in;
        aport_s2_r <= aport_s1_r;
        eport_s1_r <= ext_port_in;
        eport_s2_r <= eport_s1_r;
        a1_s1_r <= adp_ctrl_first_in;
        a1_s2_r <= a1_s1_r;
        a2_s1_r <= adp_ctrl_second_in;
        a2_s2_r <= a2_s1_r;
        a2oe_s1_r <= adp_ctrl_second_oe_in;
        a2oe_s2_r <= a2oe_s1_r;
        e1_s1_r <= ext_ctrl_first_in;
        e1_s2_r <= e1_s1_r;
        e2_s1_r <= ext_ctrl_second_in;
        e2_s2_r <= e2_s1_r;
    end

    // bank qualification: bank_addr_n high = lower bank
    function automatic logic bank_ok(input logic en, input logic choice, input logic bank_n);
        bank_ok = !en || (choice ? !bank_n : bank_n);
    endfunction : bank_ok

    logic bank_match;
    logic page_match;
    logic addr_valid;
    logic [LOW_ADDR_W-1:0] low_addr;
    assign bank_match = bank_ok(cfg_s2_r.bank_enable_switch, cfg_s2_r.bank_choice_switch,
                                bus_s2_r.bank_addr_n);
    // switch closed = 1; bus lines are active low, so compare the inverted page
    assign page_match = (~bus_s2_r.upper_addr_n == cfg_s2_r.base_page_switches);
    // bits five to seven are not looked at, so the 32 registers mirror in the page
    assign addr_valid = bank_match && page_match;
    assign low_addr = ~bus_s2_r.low_addr_n;

    logic [DATA_W-1:0] bus_data_n_r;
    logic bus_data_oe_r;
    logic module_active_n_r;
    logic bus_irq_n_r;
    mbdio_adp_ctl_t adp_ctl_r;
    logic [DATA_W-1:0] adp_data_r;

    // bus side transfer; reads drive the bus, writes feed the adapters
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            bus_data_n_r <= DATA_IDLE_N;
            bus_data_oe_r <= 1'b0;
            module_active_n_r <= 1'b1;
            adp_data_r <= '0;
        end
        else
        begin
            bus_data_oe_r <= addr_valid && !bus_s2_r.read_write_n;
            module_active_n_r <= !addr_valid;
            bus_data_n_r <= ~adat_s2_r[low_addr[LOW_ADDR_W-1]];
            if (addr_valid && bus_s2_r.read_write_n)
                adp_data_r <= ~bdat_s2_r;
        end
    end

    // control buffers and chip select
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            adp_ctl_r <= '0;
            bus_irq_n_r <= 1'b1;
        end
        else
        begin
            adp_ctl_r.read_write <= bus_s2_r.read_write_n;
            adp_ctl_r.phase2 <= !bus_s2_r.phase2_n;
            adp_ctl_r.reset_n <= bus_s2_r.reset_n;
            adp_ctl_r.reg_sel <= low_addr[REG_SEL_W-1:0];
            adp_ctl_r.chip_sel[0] <= addr_valid && !low_addr[LOW_ADDR_W-1];
            adp_ctl_r.chip_sel[1] <= addr_valid && low_addr[LOW_ADDR_W-1];
            bus_irq_n_r <= &irq_s2_r;
        end
    end

    // strap pair per line: 2'b01 input, 2'b10 output, 2'b11 bypass; 2'b00 is miswired
    // and is treated as input, the safest drive state
    function automatic logic [1:0] strap_pair(input logic [STRAP_W-1:0] s, input int idx);
        strap_pair = {s[2*idx+1], s[2*idx]};
    endfunction : strap_pair

    logic [NUM_PORTS-1:0] port_tx;
    logic [NUM_PORTS-1:0] first_out_dir, second_out_dir, second_bypass;

    // line index: per adapter k, 3k = A second, 3k+1 = B first, 3k+2 = B second
    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++)
        begin : g_port
            localparam int ADP = g / 2;
            // manual switch closed (1) = manual mode; second line high = transmit
            assign port_tx[g] = cfg_s2_r.prog_manual_switches[g] ? cfg_s2_r.port_dir_switches[g]
                                                                 : a2_s2_r[g];
            if (g % 2 == 0)
            begin : g_port_a
                // first A-side line has no output mode and stays input
                assign first_out_dir[g] = 1'b0;
                assign second_out_dir[g] = strap_pair(cfg_s2_r.ctrl_dir_straps, 3*ADP) == 2'b10;
                assign second_bypass[g] = strap_pair(cfg_s2_r.ctrl_dir_straps, 3*ADP) == 2'b11;
            end
            else
            begin : g_port_b
                assign first_out_dir[g] = strap_pair(cfg_s2_r.ctrl_dir_straps, 3*ADP+1) == 2'b10;
                // bypass on the first line has no adapter drive enable to follow, so it stays input
                assign second_out_dir[g] = strap_pair(cfg_s2_r.ctrl_dir_straps, 3*ADP+2) == 2'b10;
                assign second_bypass[g] = strap_pair(cfg_s2_r.ctrl_dir_straps, 3*ADP+2) == 2'b11;
            end
        end
    endgenerate

    logic [DATA_W-1:0] adp_port_r [NUM_PORTS];
    logic [DATA_W-1:0] ext_port_r [NUM_PORTS];
    logic [NUM_PORTS-1:0] ext_port_oe_r;

    // the whole byte turns at once, so mixed-direction ports are not possible
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            ext_port_oe_r <= '0;
            for (int i = 0; i < NUM_PORTS; i++)
            begin
                adp_port_r[i] <= '0;
                ext_port_r[i] <= '0;
            end
        end
        else
        begin
            ext_port_oe_r <= port_tx;
            for (int i = 0; i < NUM_PORTS; i++)
            begin
                ext_port_r[i] <= aport_s2_r[i];
                adp_port_r[i] <= eport_s2_r[i];
            end
        end
    end

    logic [NUM_PORTS-1:0] adp_c1_r, adp_c2_r, ext_c1_r, ext_c2_r, ext_c1_oe_r, ext_c2_oe_r;

    // second-line bypass follows the adapter's own drive enable, as a direct wire would
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            adp_c1_r <= '0;
            adp_c2_r <= '0;
            ext_c1_r <= '0;
            ext_c2_r <= '0;
            ext_c1_oe_r <= '0;
            ext_c2_oe_r <= '0;
        end
        else
        begin
            adp_c1_r <= e1_s2_r;
            adp_c2_r <= e2_s2_r;
            ext_c1_r <= a1_s2_r;
            ext_c2_r <= a2_s2_r;
            ext_c1_oe_r <= first_out_dir;
            ext_c2_oe_r <= second_out_dir | (second_bypass & a2oe_s2_r);
        end
    end

    assign bus_data_n_out = bus_data_n_r;
    assign bus_data_oe_out = bus_data_oe_r;
    assign module_active_n_out = module_active_n_r;
    assign bus_irq_n_out = bus_irq_n_r;
    assign adp_ctl_out = adp_ctl_r;
    assign adp_data_out = adp_data_r;
    assign adp_port_out = adp_port_r;
    assign ext_port_out = ext_port_r;
    assign ext_port_oe_out = ext_port_oe_r;
    assign adp_ctrl_first_out = adp_c1_r;
    assign adp_ctrl_second_out = adp_c2_r;
    assign ext_ctrl_first_out = ext_c1_r;
    assign ext_ctrl_second_out = ext_c2_r;
    assign ext_ctrl_first_oe_out = ext_c1_oe_r;
    assign ext_ctrl_second_oe_out = ext_c2_oe_r;

    bus_active_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        addr_valid |=> !module_active_n_out)
        else $error("active output not low after valid address");
    one_select_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !(adp_ctl_out.chip_sel[0] && adp_ctl_out.chip_sel[1]))
        else $error("both chip selects asserted");
    sel_valid_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        $past(!addr_valid) |-> (adp_ctl_out.chip_sel == '0 && !bus_data_oe_out))
        else $error("select or drive without valid address");
    read_drive_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (addr_valid && !bus_s2_r.read_write_n) |=> bus_data_oe_out && !module_active_n_out)
        else $error("read did not drive bus");
    write_data_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (addr_valid && bus_s2_r.read_write_n) |=> adp_data_out == ~$past(bdat_s2_r))
        else $error("write data not inverted into adapter");
    irq_merge_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (irq_s2_r != '1) |=> !bus_irq_n_out)
        else $error("adapter interrupt not forwarded");
    bank_lower_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (cfg_s2_r.bank_enable_switch && !cfg_s2_r.bank_choice_switch && !bus_s2_r.bank_addr_n)
        |=> module_active_n_out)
        else $error("lower-bank module answered upper bank");
    manual_dir_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        cfg_s2_r.prog_manual_switches[0] |=> ext_port_oe_out[0] == $past(cfg_s2_r.port_dir_switches[0]))
        else $error("manual direction not followed");
    prog_dir_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !cfg_s2_r.prog_manual_switches[1] |=> ext_port_oe_out[1] == $past(a2_s2_r[1]))
        else $error("programmed direction not followed");
    reg_select_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        1'b1 |=> adp_ctl_out.reg_sel == ~$past(bus_s2_r.low_addr_n[REG_SEL_W-1:0]))
        else $error("register select not inverted from address");
endmodule : mbdio_bridge

// [mbdio_far_model.sv]
module mbdio_far_model
    import mbdio_pkg::*;
(
    // adapter bus side
    input wire mbdio_adp_ctl_t adp_ctl_in,
    output logic [DATA_W-1:0] adp_data_out [NUM_ADAPTERS],
    // adapter port side
    input wire logic out_mode_in,
    output logic [DATA_W-1:0] adp_port_out [NUM_PORTS],
    output logic [NUM_PORTS-1:0] ctrl_second_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;

    always_comb
    begin
        for (int k = 0; k < NUM_ADAPTERS; k++)
        begin
            adp_data_out[k] = {3'h5, k[0], adp_ctl_in.reg_sel};
            // an unselected adapter has let go, so never show the byte it would return
            if (!adp_ctl_in.chip_sel[k])
            begin
                adp_data_out[k] = ~adp_data_out[k];
            end
        end
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            adp_port_out[p] = {4'h6, 2'(p), 2'h1};
        end
    end

    assign ctrl_second_oe_out = {NUM_PORTS{out_mode_in}};
endmodule : mbdio_far_model

// [mbdio_pkg.sv]
package mbdio_pkg;
    localparam int DATA_W = 8;
    localparam int REG_SEL_W = 4;
    localparam int LOW_ADDR_W = 5;
    localparam int UPPER_ADDR_W = 8;
    localparam int NUM_PORTS = 4;
    localparam int NUM_ADAPTERS = 2;
    localparam int CFG_CTRL_LINES = 6;
    localparam int STRAP_W = 12;
    localparam int SYNC_STAGES = 2;
    localparam logic [UPPER_ADDR_W-1:0] BASE_PAGE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] DATA_IDLE_N = 8'hFF;

    typedef struct packed {
        logic read_write_n;
        logic phase2_n;
        logic reset_n;
        logic bank_addr_n;
        logic [UPPER_ADDR_W-1:0] upper_addr_n;
        logic [LOW_ADDR_W-1:0] low_addr_n;
    } mbdio_bus_ctl_t;

    typedef struct packed {
        logic [UPPER_ADDR_W-1:0] base_page_switches;
        logic bank_choice_switch;
        logic bank_enable_switch;
        logic [NUM_PORTS-1:0] port_dir_switches;
        logic [NUM_PORTS-1:0] prog_manual_switches;
        logic [STRAP_W-1:0] ctrl_dir_straps;
    } mbdio_cfg_t;

    typedef struct packed {
        logic read_write;
        logic phase2;
        logic reset_n;
        logic [REG_SEL_W-1:0] reg_sel;
        logic [NUM_ADAPTERS-1:0] chip_sel;
    } mbdio_adp_ctl_t;
endpackage : mbdio_pkg

// [tb_top.sv]
module tb_top
    import mbdio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    mbdio_bus_ctl_t bus = '0;
    mbdio_cfg_t cfg = '0;
    logic [7:0] bus_d_n_in = 8'hFF;
    logic [7:0] bus_d_n, adp_d_out;
    logic bus_oe, irq_n, act_n, out_mode = 1'b0;
    mbdio_adp_ctl_t adp_ctl;
    logic [7:0] adp_d [NUM_ADAPTERS];
    logic [1:0] adp_irq_n = 2'h3;
    logic [7:0] adp_pi [NUM_PORTS];
    logic [7:0] adp_po [NUM_PORTS];
    logic [7:0] ext_pi [NUM_PORTS] = '{8'h90, 8'h91, 8'h92, 8'h93};
    logic [7:0] ext_po [NUM_PORTS];
    logic [3:0] ext_poe, a1o, a2o, e1o, e2o, e1oe, e2oe, a2oe;
    logic [3:0] a1i = 4'hC, a2i = 4'h0, e1i = 4'h5, e2i = 4'h3;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;

    always #12.5 sys_clk = ~sys_clk;

    mbdio_far_model far (.adp_ctl_in(adp_ctl), .adp_data_out(adp_d), .out_mode_in(out_mode),
        .adp_port_out(adp_pi), .ctrl_second_oe_out(a2oe));

    mbdio_bridge uut (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .bus_ctl_in(bus),
        .bus_data_n_in(bus_d_n_in), .bus_data_n_out(bus_d_n), .bus_data_oe_out(bus_oe),
        .bus_irq_n_out(irq_n), .module_active_n_out(act_n), .cfg_in(cfg), .adp_ctl_out(adp_ctl),
        .adp_data_in(adp_d), .adp_data_out(adp_d_out), .adp_irq_n_in(adp_irq_n),
        .adp_port_in(adp_pi), .adp_port_out(adp_po), .ext_port_in(ext_pi), .ext_port_out(ext_po),
        .ext_port_oe_out(ext_poe), .adp_ctrl_first_in(a1i), .adp_ctrl_second_in(a2i),
        .adp_ctrl_second_oe_in(a2oe), .adp_ctrl_first_out(a1o), .adp_ctrl_second_out(a2o),
        .ext_ctrl_first_in(e1i), .ext_ctrl_second_in(e2i), .ext_ctrl_first_out(e1o),
        .ext_ctrl_second_out(e2o), .ext_ctrl_first_oe_out(e1oe), .ext_ctrl_second_oe_out(e2oe));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // outputs trail inputs by two sync stages and one register
    task automatic settle();
        repeat (4) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic access(input logic wr, input logic [15:0] addr, input logic [7:0] d);
        @(posedge sys_clk);
        bus.read_write_n <= wr;
        bus.upper_addr_n <= ~addr[15:8];
        bus.low_addr_n <= ~addr[4:0];
        bus_d_n_in <= ~d;
        settle();
    endtask : access

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            fail_count++;
            test_done();
        end
    end

    initial
    begin
        logic hit;
        repeat (8) @(posedge sys_clk);
        #1;
        chk({adp_ctl, bus_oe, act_n, irq_n}, 16'h0003);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        cfg.base_page_switches <= 8'h5A;
        for (int a = 0; a < 2; a++)
        begin
            // upper offset bits set to show the mirror
            access(1'b0, {8'h5A, 3'h7, a[0], 4'hC}, 8'h00);
            chk({adp_ctl.chip_sel, adp_ctl.reg_sel, adp_ctl.read_write, bus_oe, act_n},
                {a[0], !a[0], 4'hC, 3'h2});
            // the read byte returns through the adapter input sync stages, three edges later
            settle();
            chk(bus_d_n, {3'h5, a[0], 4'hC} ^ 8'hFF);
        end
        access(1'b0, 16'h5B00, 8'h00);
        chk({adp_ctl.chip_sel, bus_oe, act_n}, 16'h0001);
        access(1'b1, 16'h5A05, 8'hC3);
        chk({adp_d_out, adp_ctl.read_write, bus_oe, act_n}, {8'hC3, 3'h4});
        for (int i = 0; i < 8; i++)
        begin
            hit = !i[2] || (i[1] ? !i[0] : i[0]);
            @(posedge sys_clk);
            cfg.bank_enable_switch <= i[2];
            cfg.bank_choice_switch <= i[1];
            bus.bank_addr_n <= i[0];
            access(1'b0, 16'h5A00, 8'h00);
            chk({adp_ctl.chip_sel, bus_oe, act_n}, {1'b0, hit, hit, !hit});
        end
        for (int i = 0; i < 4; i++)
        begin
            @(posedge sys_clk);
            adp_irq_n <= i[1:0];
            bus.phase2_n <= i[0];
            bus.reset_n <= i[1];
            settle();
            chk({irq_n, adp_ctl.phase2, adp_ctl.reset_n}, {&i[1:0], !i[0], i[1]});
        end
        @(posedge sys_clk);
        cfg.prog_manual_switches <= 4'hF;
        cfg.port_dir_switches <= 4'h5;
        settle();
        chk(ext_poe, 4'h5);
        chk({ext_po[0], adp_po[1]}, 16'h6191);
        @(posedge sys_clk);
        cfg.port_dir_switches <= 4'hA;
        settle();
        chk({ext_poe, ext_po[1], adp_po[0]}, {4'hA, 8'h65, 8'h90});
        for (int i = 0; i < 2; i++)
        begin
            @(posedge sys_clk);
            cfg.prog_manual_switches <= 4'h0;
            cfg.port_dir_switches <= 4'hF;
            a2i <= i[0] ? 4'h9 : 4'h6;
            settle();
            chk(ext_poe, i[0] ? 4'h9 : 4'h6);
        end
        // valid strap pairs only: input, output, bypass; the miswired 2'b00 is not checked
        @(posedge sys_clk);
        cfg.ctrl_dir_straps <= 12'h555;
        settle();
        chk({e1oe, e2oe, a1o, a2o}, 16'h0053);
        @(posedge sys_clk);
        cfg.ctrl_dir_straps <= 12'hAAA;
        out_mode <= 1'b1;
        settle();
        chk({e1oe, e2oe, e1o & 4'hA, e2o}, 16'hAF89);
        for (int m = 0; m < 2; m++)
        begin
            @(posedge sys_clk);
            cfg.ctrl_dir_straps <= 12'hFFF;
            out_mode <= m[0];
            settle();
            chk(e2oe, {4{m[0]}});
        end
        test_done();
    end
endmodule : tb_top
